// File: osc_pkg.sv
// constants and types for the oscillator source control block
// Functional notes
// - Hardware sets the stable flag; the clock is held back until then.
// - An unmasked ready event of the oscillator raises the interrupt.
// - Setting enable starts the oscillator and clearing it stops it.
// - Bypass plus enable accepts an outside clock up to 48 MHz instead.
// - Bypass on two-pin parts takes the input pin, frees the output pin.
// - The 16 MHz RC clock may be the system clock after a stop wakeup.
// - On oscillator failure the RC clock can take over as backup.
// - One edge after each reset release the factory value loads into the 8-bit read-only field.
// - A 5-bit writable trim field tunes the RC clock during operation.
package osc_pkg;
   localparam int unsigned OSC_ADDR_W     = 12;
   localparam logic [11:0] OSC_CTRL_OFF   = 12'h000;
   localparam logic [11:0] OSC_CALIB_OFF  = 12'h004;
   localparam logic [11:0] OSC_ISTAT_OFF  = 12'h008;
   localparam logic [11:0] OSC_IMASK_OFF  = 12'h00C;
   localparam logic [11:0] OSC_STATUS_OFF = 12'h010;

   // control register bits
   localparam int unsigned OSC_EN_BIT     = 0;
   localparam int unsigned OSC_BYP_BIT    = 1;
   localparam int unsigned OSC_RDY_BIT    = 2;
   localparam int unsigned OSC_CSS_BIT    = 3;
   localparam int unsigned OSC_WAKE_BIT   = 4;
   localparam int unsigned OSC_SELX_BIT   = 5;

   // calibration register fields
   localparam int unsigned OSC_CAL_LSB    = 0;
   localparam int unsigned OSC_CAL_W      = 8;
   localparam int unsigned OSC_TRIM_LSB   = 8;
   localparam int unsigned OSC_TRIM_W     = 5;
   localparam logic [4:0]  OSC_TRIM_RST   = 5'h10;

   // interrupt status and mask layout
   localparam int unsigned OSC_INT_W      = 2;
   localparam int unsigned OSC_INT_RDY    = 0;
   localparam int unsigned OSC_INT_FAIL   = 1;

   // status register bits
   localparam int unsigned OSC_STS_EXT    = 0;
   localparam int unsigned OSC_STS_WAIT   = 1;

   localparam int unsigned OSC_RC_MHZ     = 16;
   localparam int unsigned OSC_BYP_MAX_MHZ = 48;

   localparam int unsigned OSC_CLK_PERIOD_NS = 20;
   localparam int unsigned OSC_STAB_TIME_NS  = 2000;
   localparam int unsigned OSC_STAB_CYCLES   =
      (OSC_STAB_TIME_NS + OSC_CLK_PERIOD_NS - 1) / OSC_CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      OSC_SRC_RC,
      OSC_SRC_WAIT,
      OSC_SRC_EXT
   } osc_src_t;
endpackage

// File: osc_source_ctrl.sv
// oscillator source control with apb registers and interrupt
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
module osc_source_ctrl #(
   parameter int unsigned STAB_CYCLES   = osc_pkg::OSC_STAB_CYCLES,
   parameter bit          HAS_BOTH_PINS = 1'b1
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_clk_present,
   input  wire logic        stop_wakeup,
   input  wire logic [7:0]  factory_cal,
   output logic             ext_osc_amp_en,
   output logic             ext_osc_bypass,
   output logic             ext_clk_in_en,
   output logic             clock_input_pin_sel,
   output logic             oscillator_output_pin_release,
   output logic             ext_clk_gate_en,
   output logic             sysclk_sel_ext,
   output logic [7:0]       rc_factory_calibration,
   output logic [4:0]       rc_user_trim,
   output logic             irq
);
   logic                 en_reg, en_next;
   logic                 byp_reg, byp_next;
   logic                 css_reg, css_next;
   logic                 wake_reg, wake_next;
   logic                 selx_reg, selx_next;
   logic [7:0]           cal_reg, cal_next;
   logic                 calp_reg, calp_next;
   logic [4:0]           trim_reg, trim_next;
   logic [1:0]           stat_reg, stat_next;
   logic [1:0]           mask_reg, mask_next;
   logic [31:0]          rdata_reg, rdata_next;
   logic                 irq_reg, irq_next;
   logic                 rdy_d_reg, rdy_d_next;
   osc_pkg::osc_src_t    src_reg, src_next;
   logic                 sysx_reg, sysx_next;

   logic                 wr_acc;
   logic                 rd_setup;
   logic                 hit_ctrl, hit_calib, hit_stat, hit_mask, hit_sts;
   logic                 hit_any;
   logic                 fail_evt;
   logic                 wake_rc;
   logic [1:0]           evt;
   logic [1:0]           clr;
   logic [31:0]          rd_mux;
   logic                 ext_osc_stable_seen;

   osc_stab_if stab ();

   osc_stab_timer #(
      .CYCLES (STAB_CYCLES)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .stab    (stab)
   );

   // oscillator runs only while enabled and a clock is seen
   assign stab.run = en_reg & ext_clk_present;

   assign hit_ctrl  = (paddr == osc_pkg::OSC_CTRL_OFF);
   assign hit_calib = (paddr == osc_pkg::OSC_CALIB_OFF);
   assign hit_stat  = (paddr == osc_pkg::OSC_ISTAT_OFF);
   assign hit_mask  = (paddr == osc_pkg::OSC_IMASK_OFF);
   assign hit_sts   = (paddr == osc_pkg::OSC_STATUS_OFF);
   assign hit_any   = hit_ctrl | hit_calib | hit_stat | hit_mask | hit_sts;
   assign wr_acc    = psel & penable & pwrite & hit_any;
   assign rd_setup  = psel & ~penable & ~pwrite;

   // zero wait state; read data is captured in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   // loss of clock while settled counts as failure only with detection on
   assign fail_evt = css_reg & stab.stable & ~ext_clk_present;
   assign wake_rc  = stop_wakeup & wake_reg;
   assign evt[osc_pkg::OSC_INT_RDY]  = stab.stable & ~rdy_d_reg;
   assign evt[osc_pkg::OSC_INT_FAIL] = fail_evt;
   assign clr = (wr_acc & hit_stat) ? pwdata[1:0] : 2'h0;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[osc_pkg::OSC_EN_BIT]   = en_reg;
         rd_mux[osc_pkg::OSC_BYP_BIT]  = byp_reg;
         rd_mux[osc_pkg::OSC_RDY_BIT]  = stab.stable;
         rd_mux[osc_pkg::OSC_CSS_BIT]  = css_reg;
         rd_mux[osc_pkg::OSC_WAKE_BIT] = wake_reg;
         rd_mux[osc_pkg::OSC_SELX_BIT] = selx_reg;
      end else if (hit_calib) begin
         rd_mux[osc_pkg::OSC_CAL_LSB +: osc_pkg::OSC_CAL_W]   = cal_reg;
         rd_mux[osc_pkg::OSC_TRIM_LSB +: osc_pkg::OSC_TRIM_W] = trim_reg;
      end else if (hit_stat) begin
         rd_mux[1:0] = stat_reg;
      end else if (hit_mask) begin
         rd_mux[1:0] = mask_reg;
      end else if (hit_sts) begin
         rd_mux[osc_pkg::OSC_STS_EXT]  = sysx_reg;
         rd_mux[osc_pkg::OSC_STS_WAIT] = (src_reg == osc_pkg::OSC_SRC_WAIT);
      end
   end

   always_comb begin
      en_next    = en_reg;
      byp_next   = byp_reg;
      css_next   = css_reg;
      wake_next  = wake_reg;
      selx_next  = selx_reg;
      trim_next  = trim_reg;
      mask_next  = mask_reg;
      rdata_next = rdata_reg;
      rdy_d_next = stab.stable;
      calp_next  = 1'b0;
      cal_next   = cal_reg;
      // strap taken one edge after release, never under reset
      if (calp_reg) begin
         cal_next = factory_cal;
      end
      if (wr_acc && hit_ctrl) begin
         en_next   = pwdata[osc_pkg::OSC_EN_BIT];
         css_next  = pwdata[osc_pkg::OSC_CSS_BIT];
         wake_next = pwdata[osc_pkg::OSC_WAKE_BIT];
         selx_next = pwdata[osc_pkg::OSC_SELX_BIT];
         // bypass only changes while the oscillator is off
         if (!en_reg) begin
            byp_next = pwdata[osc_pkg::OSC_BYP_BIT];
         end
      end
      if (wr_acc && hit_calib) begin
         trim_next =
            pwdata[osc_pkg::OSC_TRIM_LSB +: osc_pkg::OSC_TRIM_W];
      end
      if (wr_acc && hit_mask) begin
         mask_next = pwdata[1:0];
      end
      if (fail_evt) begin
         en_next = 1'b0;
      end
      if (wake_rc) begin
         selx_next = 1'b0;
      end
      // set wins over a simultaneous write-one clear
      stat_next = (stat_reg & ~clr) | evt;
      irq_next  = |(stat_next & mask_next);
      if (rd_setup) begin
         rdata_next = rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_reg    <= 1'b0;
         byp_reg   <= 1'b0;
         css_reg   <= 1'b0;
         wake_reg  <= 1'b0;
         selx_reg  <= 1'b0;
         cal_reg   <= 8'h00;
         calp_reg  <= 1'b1;
         trim_reg  <= osc_pkg::OSC_TRIM_RST;
         stat_reg  <= 2'h0;
         mask_reg  <= 2'h0;
         rdata_reg <= 32'h0000_0000;
         irq_reg   <= 1'b0;
         rdy_d_reg <= 1'b0;
      end else begin
         en_reg    <= en_next;
         byp_reg   <= byp_next;
         css_reg   <= css_next;
         wake_reg  <= wake_next;
         selx_reg  <= selx_next;
         cal_reg   <= cal_next;
         calp_reg  <= calp_next;
         trim_reg  <= trim_next;
         stat_reg  <= stat_next;
         mask_reg  <= mask_next;
         rdata_reg <= rdata_next;
         irq_reg   <= irq_next;
         rdy_d_reg <= rdy_d_next;
      end
   end

   // system clock source: rc unless external is settled and requested
   always_comb begin
      src_next = src_reg;
      unique case (src_reg)
         osc_pkg::OSC_SRC_RC: begin
            if (selx_reg && en_reg) begin
               src_next = osc_pkg::OSC_SRC_WAIT;
            end
         end
         osc_pkg::OSC_SRC_WAIT: begin
            // wakeup must not let a late settle switch to external
            if (!(selx_reg && en_reg) || wake_rc) begin
               src_next = osc_pkg::OSC_SRC_RC;
            end else if (stab.stable && stab.run) begin
               src_next = osc_pkg::OSC_SRC_EXT;
            end
         end
         osc_pkg::OSC_SRC_EXT: begin
            if (fail_evt || wake_rc || !selx_reg || !stab.run) begin
               src_next = osc_pkg::OSC_SRC_RC;
            end
         end
         default: begin
            src_next = osc_pkg::OSC_SRC_RC;
         end
      endcase
      sysx_next = (src_next == osc_pkg::OSC_SRC_EXT);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_reg  <= osc_pkg::OSC_SRC_RC;
         sysx_reg <= 1'b0;
      end else begin
         src_reg  <= src_next;
         sysx_reg <= sysx_next;
      end
   end

   assign prdata                 = rdata_reg;
   assign irq                    = irq_reg;
   assign ext_osc_amp_en         = en_reg & ~byp_reg;
   assign ext_osc_bypass         = en_reg & byp_reg;
   assign ext_clk_in_en          = en_reg;
   // single-pin parts take the outside clock on the dedicated input
   assign clock_input_pin_sel    = en_reg & byp_reg & ~HAS_BOTH_PINS;
   assign oscillator_output_pin_release =
      en_reg & byp_reg & HAS_BOTH_PINS;
   assign ext_clk_gate_en        = stab.stable;
   assign sysclk_sel_ext         = sysx_reg;
   assign rc_factory_calibration = cal_reg;
   assign rc_user_trim           = trim_reg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ext_needs_stable: assert property (
      sysclk_sel_ext |-> ext_clk_gate_en && ext_osc_stable_seen)
      else $error("external clock used before it settled");
   a_rdy_sets_flag: assert property (
      $rose(ext_clk_gate_en) |-> ##1 stat_reg[osc_pkg::OSC_INT_RDY])
      else $error("ready event did not set status");
   a_irq_gated: assert property (
      irq |-> $past(stat_next & mask_next) != 2'h0)
      else $error("interrupt raised without unmasked event");
   a_enable_starts: assert property (
      wr_acc && hit_ctrl && pwdata[osc_pkg::OSC_EN_BIT] && !fail_evt
      |=> ext_clk_in_en)
      else $error("enable write did not start oscillator");
   a_bypass_no_amp: assert property (
      ext_osc_bypass |-> !ext_osc_amp_en)
      else $error("crystal amplifier on in bypass");
   a_pin_release: assert property (
      oscillator_output_pin_release |-> ext_osc_bypass && !clock_input_pin_sel)
      else $error("output pin released outside bypass");
   a_wake_to_rc: assert property (
      stop_wakeup && wake_reg |=> !sysclk_sel_ext && !selx_reg)
      else $error("wakeup did not select rc clock");
   a_fail_backup: assert property (
      fail_evt |=> !sysclk_sel_ext && !en_reg ##1 !ext_clk_gate_en)
      else $error("failure did not fall back to rc");
   a_cal_loaded: assert property (
      // release edge itself still shows reset values
      presetn && calp_reg
      |=> rc_factory_calibration == $past(factory_cal) && !calp_reg)
      else $error("factory calibration not loaded");
   a_trim_write: assert property (
      wr_acc && hit_calib |=> rc_user_trim == $past(pwdata[12:8]))
      else $error("trim write not applied");
   a_off_clears: assert property (
      $fell(en_reg) |-> ##1 !ext_clk_gate_en [*2])
      else $error("stable flag kept after disable");

   c_ready_seen: cover property ($rose(ext_clk_gate_en));
   c_ext_selected: cover property ($rose(sysclk_sel_ext));
   c_fail_backup: cover property (fail_evt ##1 !sysclk_sel_ext);
   c_wake_rc: cover property (wake_rc && sysclk_sel_ext);

   assign ext_osc_stable_seen = stab.stable;
endmodule

// File: osc_stab_if.sv
// settling handshake between the control logic and its timer
`timescale 1ns/10ps
interface osc_stab_if;
   logic run;
   logic stable;
   modport timer (input run, output stable);
   modport ctrl  (output run, input stable);
endinterface

// File: osc_stab_timer.sv
// settling timer of the external oscillator
`timescale 1ns/10ps
module osc_stab_timer #(
   parameter int unsigned CYCLES = osc_pkg::OSC_STAB_CYCLES
) (
   input wire logic   pclk,
   input wire logic   presetn,
   osc_stab_if.timer  stab
);
   localparam int unsigned CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          stable_reg;
   logic          stable_next;

   always_comb begin
      cnt_next    = cnt_reg;
      stable_next = stable_reg;
      if (!stab.run) begin
         // any drop restarts the full interval
         cnt_next    = '0;
         stable_next = 1'b0;
      end else if (!stable_reg) begin
         if (cnt_reg == LAST) begin
            stable_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg    <= '0;
         stable_reg <= 1'b0;
      end else begin
         cnt_reg    <= cnt_next;
         stable_reg <= stable_next;
      end
   end

   assign stab.stable = stable_reg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_stab_full_count: assert property (
      $rose(stable_reg) |-> $past(cnt_reg) == LAST && $past(stab.run))
      else $error("stable flag rose before full settling count");
endmodule

// File: osc_xtal_model.sv
// behavioural outside clock source facing the oscillator control
`timescale 1ns/10ps
module osc_xtal_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       drive_req,
   input  wire logic       fail,
   input  wire logic [3:0] delay,
   output logic            present
);
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic       present_next;
   always_comb begin
      cnt_next = cnt_reg;
      present_next = 1'b0;
      // a failed or unpowered source shows no clock at all
      if (!drive_req || fail) begin
         cnt_next = 4'h0;
      end else if (cnt_reg < delay) begin
         cnt_next = cnt_reg + 4'h1;
      end else begin
         present_next = 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 4'h0;
         present <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         present <= present_next;
      end
   end
endmodule

// File: test_oscillator_source_control.sv
// self-checking bench for the oscillator source control block
`timescale 1ns/10ps
module test_oscillator_source_control;
   localparam int unsigned STAB = 4;
   localparam logic [11:0] CTRL = osc_pkg::OSC_CTRL_OFF;
   localparam logic [11:0] CALB = osc_pkg::OSC_CALIB_OFF;
   localparam logic [11:0] ISTA = osc_pkg::OSC_ISTAT_OFF;
   localparam logic [11:0] IMSK = osc_pkg::OSC_IMASK_OFF;
   localparam logic [11:0] STAT = osc_pkg::OSC_STATUS_OFF;
   localparam logic [4:0]  TRST = osc_pkg::OSC_TRIM_RST;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        present, stop_wakeup, fail, amp_en, byp, in_en, pin_sel;
   logic        out_rel, gate, sel_ext, irq;
   logic [7:0]  factory_cal, rc_cal;
   logic [4:0]  trim;
   logic [3:0]  xdly;
   int          fails, tests_run;

   osc_source_ctrl #(.STAB_CYCLES(STAB)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_clk_present(present),
      .stop_wakeup(stop_wakeup), .factory_cal(factory_cal),
      .ext_osc_amp_en(amp_en), .ext_osc_bypass(byp), .ext_clk_in_en(in_en),
      .clock_input_pin_sel(pin_sel), .oscillator_output_pin_release(out_rel),
      .ext_clk_gate_en(gate), .sysclk_sel_ext(sel_ext),
      .rc_factory_calibration(rc_cal), .rc_user_trim(trim), .irq(irq));
   osc_xtal_model xtal (.pclk(pclk), .presetn(presetn), .drive_req(in_en),
      .fail(fail), .delay(xdly), .present(present));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic close_out;
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask

   task automatic give_up;
      fails++;
      close_out();
   endtask

   // apb master: hold the request until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) give_up();
      q = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   // enable and wait for the settled flag, never using the clock early
   task automatic bring_up(input logic [31:0] c);
      int n;
      apb(1'b1, CTRL, c);
      n = 0;
      while (gate !== 1'b1 && n < 60) begin
         @(posedge pclk);
         n++;
         if (sel_ext !== 1'b0) chk("sysclk before stable", 0, 1);
      end
      if (n >= 60) give_up();
      chk("settle cycles", 1, n >= STAB);
      chk("amp enable", !c[1], amp_en);
      n = 0;
      while (c[5] && sel_ext !== 1'b1 && n < 8) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 8) give_up();
   endtask

   task automatic t_regs;
      apb(1'b0, CALB, 0);
      chk("calib reset", {19'h0, TRST, factory_cal}, q);
      apb(1'b1, CALB, 32'h0000_1FFF);
      apb(1'b0, CALB, 0);
      chk("calib trim", {19'h0, 5'h1F, factory_cal}, q);
      chk("trim port", 5'h1F, trim);
      chk("cal port", factory_cal, rc_cal);
      apb(1'b0, 12'h014, 0);
      chk("unmapped err", 1, se);
      chk("unmapped data", 0, q);
      apb(1'b1, CTRL, 32'h0000_0004);
      apb(1'b0, CTRL, 0);
      chk("stable flag ro", 0, q);
   endtask

   task automatic t_ready_irq;
      bring_up(32'h0000_0021);
      chk("sysclk ext", 1, sel_ext);
      apb(1'b0, STAT, 0);
      chk("status ext", 32'h0000_0001, q);
      apb(1'b0, ISTA, 0);
      chk("ready event", 1, q[0]);
      chk("irq masked", 0, irq);
      apb(1'b1, IMSK, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      chk("irq raised", 1, irq);
      apb(1'b1, ISTA, 32'h0000_0003);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 0, irq);
      apb(1'b0, CTRL, 0);
      chk("ctrl flag", 1, q[2]);
   endtask

   task automatic t_disable;
      apb(1'b1, CTRL, 0);
      repeat (2) @(posedge pclk);
      chk("amp off", 0, amp_en);
      chk("gate off", 0, gate);
      apb(1'b0, CTRL, 0);
      chk("ctrl off", 0, q);
      bring_up(32'h0000_0001);
      apb(1'b1, CTRL, 0);
   endtask

   task automatic t_bypass;
      xdly <= 4'h9;
      apb(1'b1, CTRL, 32'h0000_0002);
      bring_up(32'h0000_0003);
      chk("bypass out", 1, byp);
      chk("clock in en", 1, in_en);
      chk("out pin free", 1, out_rel);
      chk("ck pin unused", 0, pin_sel);
      apb(1'b1, CTRL, 32'h0000_0001);
      chk("bypass held", 1, byp);
      apb(1'b1, CTRL, 0);
      xdly <= 4'h1;
   endtask

   task automatic t_fail;
      int n;
      bring_up(32'h0000_0029);
      fail <= 1'b1;
      n = 0;
      while (sel_ext !== 1'b0 && n < 6) begin
         @(posedge pclk);
         n++;
      end
      chk("fallback in time", 1, n < 6);
      apb(1'b0, ISTA, 0);
      chk("fail event", 1, q[1]);
      apb(1'b0, CTRL, 0);
      chk("enable dropped", 0, q[0]);
      fail <= 1'b0;
      apb(1'b1, ISTA, 32'h0000_0003);
   endtask

   task automatic t_wake;
      bring_up(32'h0000_0031);
      stop_wakeup <= 1'b1;
      @(posedge pclk);
      stop_wakeup <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("rc after wake", 0, sel_ext);
      apb(1'b0, CTRL, 0);
      chk("ext request off", 0, q[5]);
      apb(1'b1, CTRL, 0);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      stop_wakeup = 1'b0;
      fail = 1'b0;
      xdly = 4'h1;
      factory_cal = 8'h5A;
      fails = 0;
      tests_run = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      t_regs();
      t_ready_irq();
      t_disable();
      t_bypass();
      t_fail();
      t_wake();
      factory_cal <= 8'hC3;
      do_reset();
      apb(1'b0, CALB, 0);
      chk("calib rereset", {19'h0, TRST, 8'hC3}, q);
      close_out();
   end
endmodule
